// >>> common/cfg_info_pkg.sv
// =====================================================================
// Shared constants, types and helpers of the configuration info link
// =====================================================================
// Holds beat layout, message codes, register map and field encoders.
// Assumes both link ends and the bench compile it first.
package cfg_info_pkg;

  // Header beat codes: data = {cmd, ext}
  localparam logic [3:0] CMD_CAP = 4'h1;
  localparam logic [3:0] CMD_NAME = 4'h2;
  localparam logic [3:0] EXT_QUERY = 4'h1;
  localparam logic [3:0] EXT_DEFINE = 4'h2;
  localparam logic [3:0] EXT_RECORD = 4'h3;
  localparam logic [3:0] EXT_END = 4'h4;
  localparam logic [3:0] EXT_ERR = 4'h5;

  // Field limits, in characters and values
  localparam logic [6:0] NUM_MAX = 7'h63;
  localparam logic [4:0] NAME_LEN_MAX = 5'h10;
  localparam int NAME_DEPTH = 8;
  localparam logic [4:0] CAUSE_LEN = 5'h04;
  localparam logic [31:0] CAUSE_RECORD_COUNT = 32'h4e524543;
  localparam logic [7:0] CHAR_ZERO = 8'h30;

  // Controller register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_CAP = 8'h0c;
  localparam logic [7:0] REG_RECORD_COUNT = 8'h10;

  // Field positions
  localparam int CTRL_CAPQ = 0;
  localparam int CTRL_NAMEQ = 1;
  localparam int CTRL_BUSY = 2;
  localparam int ST_CAP = 0;
  localparam int ST_CLOSED = 1;
  localparam int ST_ERR_RX = 2;
  localparam int ST_PROTO = 3;
  localparam int ST_W = 4;
  localparam int RECORD_COUNT_GOT = 8;
  localparam int RECORD_COUNT_OPEN = 16;

  typedef enum logic [2:0] {
    K_IDLE, K_CAPQ, K_NAMEQ, K_CAP, K_NDEF, K_RECORD_COUNT, K_NEND, K_NERR
  } msg_kind_t;

  typedef struct packed {
    logic [7:0] data;
    logic head;
    logic fend;
    logic last;
  } beat_t;

  // Number of characters of a decimal field
  function automatic logic [1:0] dec_len(input logic [6:0] v);
    return (v >= 7'd10) ? 2'd2 : 2'd1;
  endfunction

  // Character idx (0 first) of a decimal field
  function automatic logic [7:0] dec_char(input logic [6:0] v,
                                          input logic idx);
    logic [6:0] d;
    d = (v < 7'd10) ? v : (idx ? v % 7'd10 : v / 7'd10);
    return CHAR_ZERO + {1'b0, d};
  endfunction

  // Beat p of message k; a, b are numeric fields, nl/nc the name
  function automatic beat_t mk_beat(input msg_kind_t k,
                                    input logic [4:0] p,
                                    input logic [6:0] a,
                                    input logic [6:0] b,
                                    input logic [4:0] nl,
                                    input logic [7:0] nc);
    beat_t r;
    logic [4:0] la;
    logic [4:0] lb;
    la = {3'd0, dec_len(a)};
    lb = {3'd0, dec_len(b)};
    r = '0;
    r.head = (p == 5'd0);
    case (k)
      K_CAPQ: r.data = {CMD_CAP, EXT_QUERY};
      K_NAMEQ: r.data = {CMD_NAME, EXT_QUERY};
      K_CAP: r.data = {CMD_CAP, EXT_DEFINE};
      K_NDEF: r.data = {CMD_NAME, EXT_DEFINE};
      K_RECORD_COUNT: r.data = {CMD_NAME, EXT_RECORD};
      K_NEND: r.data = {CMD_NAME, EXT_END};
      K_NERR: r.data = {CMD_NAME, EXT_ERR};
      default: r.data = 8'h00;
    endcase
    if (r.head)
      r.last = (k == K_CAPQ) || (k == K_NAMEQ) || (k == K_NEND);
    else
    begin
      case (k)
        K_CAP:
        begin
          if (p <= la)
          begin
            r.data = dec_char(a, p == 5'd2);
            r.fend = (p == la);
          end
          else
          begin
            r.data = dec_char(b, p == la + 5'd2);
            r.fend = (p == la + lb);
            r.last = r.fend;
          end
        end
        K_NDEF:
        begin
          r.data = dec_char(a, p == 5'd2);
          r.fend = (p == la);
          r.last = r.fend;
        end
        K_RECORD_COUNT:
        begin
          r.data = nc;
          r.fend = (p == nl);
          r.last = r.fend;
        end
        K_NERR:
        begin
          r.data = CAUSE_RECORD_COUNT[8 * (4 - int'(p)) +: 8];
          r.fend = (p == CAUSE_LEN);
          r.last = r.fend;
        end
        default: r.data = 8'h00;
      endcase
    end
    return r;
  endfunction

endpackage

// >>> common/cfg_link_if.sv
// =====================================================================
// Character link between the local entity and the remote controller
// =====================================================================
// One beat per character or header; both ends share core_clk.
`timescale 1ns/1ps
interface cfg_link_if;
  logic d2h_valid;
  logic d2h_ready;
  logic d2h_head;
  logic d2h_fend;
  logic d2h_last;
  logic [7:0] d2h_data;
  logic h2d_valid;
  logic h2d_ready;
  logic h2d_head;
  logic h2d_fend;
  logic h2d_last;
  logic [7:0] h2d_data;

  modport dev (
    output d2h_valid, d2h_head, d2h_fend, d2h_last, d2h_data,
    input d2h_ready,
    input h2d_valid, h2d_head, h2d_fend, h2d_last, h2d_data,
    output h2d_ready
  );

  modport host (
    input d2h_valid, d2h_head, d2h_fend, d2h_last, d2h_data,
    output d2h_ready,
    output h2d_valid, h2d_head, h2d_fend, h2d_last, h2d_data,
    input h2d_ready
  );
endinterface

// >>> rtl/cfg_info_dev.sv
// Local entity end: answers capacity and name queries, checks sessions.
// Assumes the remote end runs on core_clk and user inputs are synchronous.
`timescale 1ns/1ps

// How it works
// - Capacity query is answered by capacity report
// - Capacity limit is decimal 1 to 99
// - Stored count is decimal 0 to limit
// - Capacity report only after a query
// - Name query opens session sending names_used names, at most 8 and the limit
// - Session opening carries record count 0..99
// - Opening, then records, then closing message
// - Records only inside an open session
// - Each record holds one 1..16 char name
// - Closing message returns to no session
// - Errors use error message with RECORD_COUNT cause
// - Fields are sized in characters
module cfg_info_dev
  import cfg_info_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Link to the remote entity
  cfg_link_if.dev link,
  // Local configuration store
  input wire logic [6:0] capacity_limit,
  input wire logic [3:0] names_used,
  input wire logic name_we,
  input wire logic [2:0] name_sel,
  input wire logic [3:0] name_pos,
  input wire logic [4:0] name_len,
  input wire logic [7:0] name_char,
  // Session events
  output logic err_rx,
  output logic bad_record,
  output logic record_count_mismatch,
  output logic session_open
);

  // ===================================================================
  // Receive side
  // ===================================================================
  logic rdy_q, rfld_q, rx_take, rx_end, close_bad;
  logic [1:0] rdig_q;
  logic [3:0] rcmd_q, rext_q, cur_cmd, cur_ext, dig;
  logic [6:0] rval_q, exp_q, got_q, nval;
  assign link.h2d_ready = rdy_q;
  assign rx_take = link.h2d_valid & rdy_q;
  assign rx_end = rx_take & link.h2d_last;
  assign cur_cmd = link.h2d_head ? link.h2d_data[7:4] : rcmd_q;
  assign cur_ext = link.h2d_head ? link.h2d_data[3:0] : rext_q;
  assign dig = 4'(link.h2d_data - CHAR_ZERO);
  assign close_bad = rx_end && cur_cmd == CMD_NAME &&
                     cur_ext == EXT_END && session_open && got_q != exp_q;
  // Decimal accumulation of the first field, two characters at most
  assign nval = link.h2d_head ? 7'h00 :
                (!rfld_q && rdig_q < 2'd2 && dig < 4'd10) ?
                7'(rval_q * 7'd10 + {3'd0, dig}) : rval_q;

  // Header capture and field tracking
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      rcmd_q <= 4'h0;
      rext_q <= 4'h0;
      rval_q <= 7'h00;
      rdig_q <= 2'd0;
      rfld_q <= 1'b0;
    end
    else if (rx_take)
    begin
      rcmd_q <= cur_cmd;
      rext_q <= cur_ext;
      rval_q <= nval;
      if (link.h2d_head)
      begin
        rdig_q <= 2'd0;
        rfld_q <= 1'b0;
      end
      else
      begin
        if (!rfld_q && rdig_q != 2'd3)
          rdig_q <= rdig_q + 2'd1;
        rfld_q <= rfld_q | link.h2d_fend;
      end
    end
  end

  // Incoming name session tracking
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      session_open <= 1'b0;
      exp_q <= 7'h00;
      got_q <= 7'h00;
      bad_record <= 1'b0;
      record_count_mismatch <= 1'b0;
      err_rx <= 1'b0;
      rdy_q <= 1'b0;
    end
    else
    begin
      bad_record <= 1'b0;
      rdy_q <= 1'b1; // Always ready for remote beats
      record_count_mismatch <= close_bad;
      err_rx <= rx_end && cur_cmd == CMD_NAME && cur_ext == EXT_ERR;
      if (rx_end && cur_cmd == CMD_NAME)
      begin
        case (cur_ext)
          EXT_DEFINE:
          begin
            session_open <= 1'b1;
            exp_q <= nval;
            got_q <= 7'h00;
          end
          EXT_RECORD:
            if (!session_open)
              bad_record <= 1'b1;
            else if (got_q != NUM_MAX)
              got_q <= got_q + 7'h01;
          EXT_END: session_open <= 1'b0;
          default: ;
        endcase
      end
    end
  end

  logic [7:0] nchar_q [NAME_DEPTH][16];
  logic [4:0] nlen_q [NAME_DEPTH];
  // Stored name characters, length kept within 1..16
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < NAME_DEPTH; i++)
        nlen_q[i] <= 5'h01;
    end
    else if (name_we)
    begin
      nchar_q[name_sel][name_pos] <= name_char;
      nlen_q[name_sel] <= (name_len == 5'h00) ? 5'h01 :
        (name_len > NAME_LEN_MAX) ? NAME_LEN_MAX : name_len;
    end
  end

  // ===================================================================
  // Transmit side
  // ===================================================================
  msg_kind_t kind_q, kind_n;
  logic [4:0] pos_q, pos_n;
  logic [3:0] rec_q, rec_n;
  logic pick, cap_pend_q, name_pend_q, err_pend_q, tx_done, valid_q;
  logic [6:0] lim_q, cnt_q, lim_now, cnt_now, fa, fb;
  beat_t beat_q, beat_n;
  assign link.d2h_valid = valid_q;
  assign link.d2h_data = beat_q.data;
  assign link.d2h_head = beat_q.head;
  assign link.d2h_fend = beat_q.fend;
  assign link.d2h_last = beat_q.last;
  assign tx_done = valid_q & link.d2h_ready & beat_q.last;

  // Clamped limit and number of names to report
  always_comb
  begin
    lim_now = (capacity_limit == 7'h00) ? 7'h01 :
      (capacity_limit > NUM_MAX) ? NUM_MAX : capacity_limit;
    cnt_now = (names_used > 4'(NAME_DEPTH)) ? 7'(NAME_DEPTH) :
      {3'd0, names_used};
    if (cnt_now > lim_now)
      cnt_now = lim_now;
  end

  // Next message and beat selection
  always_comb
  begin
    kind_n = kind_q;
    pos_n = pos_q;
    rec_n = rec_q;
    pick = 1'b0;
    if (kind_q == K_IDLE || tx_done)
    begin
      pos_n = 5'h00;
      if (tx_done && kind_q == K_NDEF)
      begin
        rec_n = 4'h0;
        kind_n = (cnt_q != 7'h00) ? K_RECORD_COUNT : K_NEND;
      end
      else if (tx_done && kind_q == K_RECORD_COUNT)
      begin
        rec_n = rec_q + 4'h1;
        kind_n = ({3'd0, rec_n} < cnt_q) ? K_RECORD_COUNT : K_NEND;
      end
      else
      begin
        pick = 1'b1;
        if (err_pend_q)
          kind_n = K_NERR;
        else if (cap_pend_q)
          kind_n = K_CAP;
        else if (name_pend_q)
          kind_n = K_NDEF;
        else
          kind_n = K_IDLE;
      end
    end
    else if (valid_q && link.d2h_ready)
      pos_n = pos_q + 5'h01;
    fa = pick ? (kind_n == K_NDEF ? cnt_now : lim_now) :
         (kind_n == K_NDEF ? cnt_q : lim_q);
    fb = pick ? cnt_now : cnt_q;
    beat_n = mk_beat(kind_n, pos_n, fa, fb, nlen_q[rec_n[2:0]],
                     nchar_q[rec_n[2:0]][4'(pos_n - 5'h01)]);
  end

  // Message sequencer and beat register
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      kind_q <= K_IDLE;
      pos_q <= 5'h00;
      rec_q <= 4'h0;
      beat_q <= '0;
      valid_q <= 1'b0;
      lim_q <= 7'h01;
      cnt_q <= 7'h00;
    end
    else
    begin
      kind_q <= kind_n;
      pos_q <= pos_n;
      rec_q <= rec_n;
      beat_q <= beat_n;
      valid_q <= (kind_n != K_IDLE);
      if (pick)
      begin
        lim_q <= lim_now;
        cnt_q <= cnt_now;
      end
    end
  end

  // Pending answers; a new request wins over the clear
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      cap_pend_q <= 1'b0;
      name_pend_q <= 1'b0;
      err_pend_q <= 1'b0;
    end
    else
    begin
      if (pick && kind_n == K_CAP)
        cap_pend_q <= 1'b0;
      if (pick && kind_n == K_NDEF)
        name_pend_q <= 1'b0;
      if (pick && kind_n == K_NERR)
        err_pend_q <= 1'b0;
      if (rx_end && cur_cmd == CMD_CAP && cur_ext == EXT_QUERY)
        cap_pend_q <= 1'b1;
      if (rx_end && cur_cmd == CMD_NAME && cur_ext == EXT_QUERY)
        name_pend_q <= 1'b1;
      if (close_bad)
        err_pend_q <= 1'b1;
    end
  end

endmodule // cfg_info_dev

// >>> rtl/cfg_info_host.sv
// Remote controller end: issues queries on software order, collects
// reports. Assumes a classic Wishbone master on core_clk.
`timescale 1ns/1ps
module cfg_info_host
  import cfg_info_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Interrupt
  output logic irq,
  // Link to the local entity
  cfg_link_if.host link
);

  // ===================================================================
  // Receive side
  // ===================================================================
  logic rx_take, rx_end, open_q, close_bad;
  logic [1:0] rfld_q;
  logic [3:0] rcmd_q, rext_q, cur_cmd, cur_ext, dig;
  logic [6:0] exp_q, got_q, lim_q, sto_q;
  logic [6:0] fv_q [2];

  assign link.d2h_ready = rst_b;
  assign rx_take = link.d2h_valid & rst_b;
  assign rx_end = rx_take & link.d2h_last;
  assign cur_cmd = link.d2h_head ? link.d2h_data[7:4] : rcmd_q;
  assign cur_ext = link.d2h_head ? link.d2h_data[3:0] : rext_q;
  assign dig = 4'(link.d2h_data - CHAR_ZERO);
  assign close_bad = rx_end && cur_cmd == CMD_NAME &&
                     cur_ext == EXT_END && open_q && got_q != exp_q;

  // Header and two decimal fields, counted in characters
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      rcmd_q <= 4'h0;
      rext_q <= 4'h0;
      rfld_q <= 2'd0;
      fv_q[0] <= 7'h00;
      fv_q[1] <= 7'h00;
    end
    else if (rx_take && link.d2h_head)
    begin
      rcmd_q <= cur_cmd;
      rext_q <= cur_ext;
      rfld_q <= 2'd0;
      fv_q[0] <= 7'h00;
      fv_q[1] <= 7'h00;
    end
    else if (rx_take)
    begin
      if (rfld_q < 2'd2 && dig < 4'd10 && fv_q[rfld_q[0]] < 7'd10)
        fv_q[rfld_q[0]] <= 7'(fv_q[rfld_q[0]] * 7'd10 + {3'd0, dig});
      if (link.d2h_fend && rfld_q != 2'd3)
        rfld_q <= rfld_q + 2'd1;
    end
  end

  // Report capture and session tracking
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      lim_q <= 7'h00;
      sto_q <= 7'h00;
      open_q <= 1'b0;
      exp_q <= 7'h00;
      got_q <= 7'h00;
    end
    else if (rx_end && cur_cmd == CMD_CAP && cur_ext == EXT_DEFINE)
    begin
      lim_q <= fv_q[0];
      sto_q <= 7'(fv_q[1] * 7'd10 + {3'd0, dig});
      if (fv_q[1] >= 7'd10 || dig >= 4'd10)
        sto_q <= fv_q[1];
    end
    else if (rx_end && cur_cmd == CMD_NAME)
    begin
      case (cur_ext)
        EXT_DEFINE:
        begin
          open_q <= 1'b1;
          exp_q <= (fv_q[0] < 7'd10 && dig < 4'd10) ?
                   7'(fv_q[0] * 7'd10 + {3'd0, dig}) : fv_q[0];
          got_q <= 7'h00;
        end
        EXT_RECORD:
          if (open_q && got_q != NUM_MAX)
            got_q <= got_q + 7'h01;
        EXT_END: open_q <= 1'b0;
        default: ;
      endcase
    end
  end

  // ===================================================================
  // Register slave and interrupt
  // ===================================================================
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] mask_q;
  logic [ST_W-1:0] ev;
  logic capq_q;
  logic nameq_q;
  logic errq_q;
  logic req;
  logic wr;
  logic [31:0] rd;
  msg_kind_t kind_q;
  msg_kind_t kind_n;
  logic [4:0] pos_q;
  beat_t beat_q;

  assign req = wb_cyc_i & wb_stb_i;
  assign wr = req & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign ev[ST_CAP] = rx_end && cur_cmd == CMD_CAP && cur_ext == EXT_DEFINE;
  assign ev[ST_CLOSED] = rx_end && cur_cmd == CMD_NAME && cur_ext == EXT_END;
  assign ev[ST_ERR_RX] = rx_end && cur_cmd == CMD_NAME && cur_ext == EXT_ERR;
  assign ev[ST_PROTO] = close_bad || (rx_end && cur_cmd == CMD_NAME &&
                        cur_ext == EXT_RECORD && !open_q);

  // Read data mux
  always_comb
  begin
    rd = 32'h0000_0000;
    case (wb_adr_i)
      REG_CTRL:
      begin
        rd[CTRL_CAPQ] = capq_q;
        rd[CTRL_NAMEQ] = nameq_q;
        rd[CTRL_BUSY] = kind_q != K_IDLE;
      end
      REG_STATUS: rd[ST_W-1:0] = status_q;
      REG_MASK: rd[ST_W-1:0] = mask_q;
      REG_CAP: rd = {17'h0, sto_q, 1'b0, lim_q};
      REG_RECORD_COUNT: rd = {15'h0, open_q, 1'b0, got_q, 1'b0, exp_q};
      default: rd = 32'h0000_0000;
    endcase
  end

  // Bus answer one cycle after the request
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req & ~wb_ack_o;
      wb_dat_o <= rd;
    end
  end

  // Sticky status, write one to clear, set wins; mask; interrupt
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      status_q <= '0;
      mask_q <= '0;
      irq <= 1'b0;
    end
    else
    begin
      if (wr && wb_adr_i == REG_STATUS)
        status_q <= (status_q & ~wb_dat_i[ST_W-1:0]) | ev;
      else
        status_q <= status_q | ev;
      if (wr && wb_adr_i == REG_MASK)
        mask_q <= wb_dat_i[ST_W-1:0];
      irq <= |(status_q & mask_q);
    end
  end

  // ===================================================================
  // Transmit side
  // ===================================================================
  assign link.h2d_valid = kind_q != K_IDLE;
  assign link.h2d_data = beat_q.data;
  assign link.h2d_head = beat_q.head;
  assign link.h2d_fend = beat_q.fend;
  assign link.h2d_last = beat_q.last;

  // Next message: error first, then queries
  always_comb
  begin
    kind_n = kind_q;
    if (kind_q == K_IDLE || (link.h2d_ready && beat_q.last))
    begin
      if (errq_q)
        kind_n = K_NERR;
      else if (capq_q)
        kind_n = K_CAPQ;
      else if (nameq_q)
        kind_n = K_NAMEQ;
      else
        kind_n = K_IDLE;
    end
  end

  // Orders from software and from the session check
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      capq_q <= 1'b0;
      nameq_q <= 1'b0;
      errq_q <= 1'b0;
      kind_q <= K_IDLE;
      pos_q <= 5'h00;
      beat_q <= '0;
    end
    else
    begin
      if (kind_n != kind_q || beat_q.last)
      begin
        if (kind_n == K_CAPQ)
          capq_q <= 1'b0;
        if (kind_n == K_NAMEQ)
          nameq_q <= 1'b0;
        if (kind_n == K_NERR)
          errq_q <= 1'b0;
      end
      if (wr && wb_adr_i == REG_CTRL && wb_dat_i[CTRL_CAPQ])
        capq_q <= 1'b1;
      if (wr && wb_adr_i == REG_CTRL && wb_dat_i[CTRL_NAMEQ])
        nameq_q <= 1'b1;
      if (close_bad)
        errq_q <= 1'b1;
      kind_q <= kind_n;
      if (kind_q == K_IDLE || (link.h2d_ready && beat_q.last))
      begin
        pos_q <= 5'h00;
        beat_q <= mk_beat(kind_n, 5'h00, 7'h00, 7'h00, 5'h01, 8'h00);
      end
      else if (link.h2d_ready)
      begin
        pos_q <= pos_q + 5'h01;
        beat_q <= mk_beat(kind_q, pos_q + 5'h01, 7'h00, 7'h00,
                          5'h01, 8'h00);
      end
    end
  end

endmodule // cfg_info_host

// >>> dv/cfg_info_chk.sv
// ==========
// Link checker
// Watches the link between the two ends.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module cfg_info_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Link beats
  input wire logic d2h_valid,
  input wire logic d2h_ready,
  input wire logic d2h_head,
  input wire logic d2h_fend,
  input wire logic d2h_last,
  input wire logic [7:0] d2h_data,
  input wire logic h2d_valid,
  input wire logic h2d_ready,
  input wire logic h2d_head,
  input wire logic [7:0] h2d_data
);
  logic [7:0] kind_q;
  logic [4:0] fcnt_q;
  logic capq_q;
  logic sess_q;
  wire dt = d2h_valid && d2h_ready;
  wire dh = dt && d2h_head;
  wire hq = h2d_valid && h2d_ready && h2d_head;
  wire dc = d2h_valid && !d2h_head;
  wire num = dc && (kind_q == 8'h12 || kind_q == 8'h22);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // Last header and chars of field
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      kind_q <= 8'h00;
    else if (dh)
      kind_q <= d2h_data;
    if (!rst_b || dh || (dt && d2h_fend))
      fcnt_q <= 5'h00;
    else if (dt)
      fcnt_q <= fcnt_q + 5'h01;
  end
  // Query waiting, session open
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || (dh && d2h_data == 8'h12))
      capq_q <= 1'b0;
    else if (hq && h2d_data == 8'h11)
      capq_q <= 1'b1;
    if (!rst_b || (dh && d2h_data == 8'h24))
      sess_q <= 1'b0;
    else if (dh && d2h_data == 8'h22)
      sess_q <= 1'b1;
  end
  a_cap_reply:
    assert property (hq && h2d_data == 8'h11 |-> ##[2:400]
      dh && d2h_data == 8'h12) else $error("no report");
  a_cap_asked:
    assert property (dh && d2h_data == 8'h12 |-> capq_q)
      else $error("report unasked");
  a_name_reply:
    assert property (hq && h2d_data == 8'h21 |-> ##[2:400]
      dh && d2h_data == 8'h22) else $error("no session");
  a_rec_inside:
    assert property (dh && d2h_data == 8'h23 |-> sess_q)
      else $error("record outside session");
  a_dec_digit:
    assert property (num |-> d2h_data inside {[8'h30:8'h39]})
      else $error("not a digit");
  a_num_width:
    assert property (num |-> fcnt_q < 5'h02)
      else $error("number too long");
  a_name_width:
    assert property (dc && kind_q == 8'h23 |-> fcnt_q < 5'h10)
      else $error("name too long");
  a_end_alone:
    assert property (dh && d2h_data == 8'h24 |-> d2h_last)
      else $error("close not alone");
endmodule // cfg_info_chk

// >>> dv/tb.sv
// ==========
// Bench of both link ends
// Software orders queries; a second device faces the bench.
// Assumes package and interface are compiled first.
`timescale 1ns/1ps
module tb
  import cfg_info_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, nwe = 1'b0;
  logic [7:0] adr = 8'h00, nch = 8'h00;
  logic [31:0] wdat = 32'h0, errw = 32'h0, q, rdat;
  logic [6:0] cap_lim = 7'h0c;
  logic [3:0] n_used = 4'h3, npos = 4'h0;
  logic [2:0] nsel = 3'h0, ev = 3'h0;
  logic [4:0] nlen = 5'h01;
  logic ack, irq;
  logic [1:0] bad, mis, erx, sopen;
  logic [6:0] lims [3] = '{7'h0c, 7'h63, 7'h00};
  logic [3:0] uses [3] = '{4'h3, 4'h8, 4'h5};
  logic [31:0] caps [3] = '{32'h030c, 32'h0863, 32'h0101};
  int fails = 0, n_compared = 0, cyc_n = 0;
  cfg_link_if lnk[2] ();
  // Both devices; the second faces the bench
  for (genvar g = 0; g < 2; g++)
  begin : gd
    cfg_info_dev cfg_info_dev_i (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .link(lnk[g]),
      .capacity_limit(cap_lim),
      .names_used(n_used),
      .name_we(nwe),
      .name_sel(nsel),
      .name_pos(npos),
      .name_len(nlen),
      .name_char(nch),
      .err_rx(erx[g]),
      .bad_record(bad[g]),
      .record_count_mismatch(mis[g]),
      .session_open(sopen[g])
    );
  end
  cfg_info_host cfg_info_host_i (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(4'hf),
    .wb_dat_i(wdat),
    .wb_dat_o(rdat),
    .wb_ack_o(ack),
    .irq(irq),
    .link(lnk[0])
  );
  cfg_info_chk cfg_info_chk_i (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .d2h_valid(lnk[0].d2h_valid),
    .d2h_ready(lnk[0].d2h_ready),
    .d2h_head(lnk[0].d2h_head),
    .d2h_fend(lnk[0].d2h_fend),
    .d2h_last(lnk[0].d2h_last),
    .d2h_data(lnk[0].d2h_data),
    .h2d_valid(lnk[0].h2d_valid),
    .h2d_ready(lnk[0].h2d_ready),
    .h2d_head(lnk[0].h2d_head),
    .h2d_data(lnk[0].h2d_data)
  );
  initial
  begin
    forever #12.5 core_clk = ~core_clk;
  end
  // Sticky events, error chars, run limit
  always @(posedge core_clk)
  begin
    cyc_n++;
    ev <= ev | {erx[1], mis[1], bad[1]};
    if (lnk[1].d2h_valid === 1'b1 && lnk[1].d2h_head === 1'b0)
      errw <= {errw[23:0], lnk[1].d2h_data};
    if (cyc_n == 20000)
    begin
      fails++;
      tally_and_finish;
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e, input string n);
    n_compared++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask
  // One classic bus cycle
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    t = 0;
    do
    begin
      @(posedge core_clk);
      t++;
    end while (ack !== 1'b1 && t < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string n);
    wb(1'b0, a, 32'h0);
    chk(q, e, n);
  endtask
  task wirq;
    int t;
    t = 0;
    while (irq !== 1'b1 && t < 500)
    begin
      @(posedge core_clk);
      t++;
    end
    chk({31'h0, irq}, 32'h1, "irq");
  endtask
  // Name of n chars A, B, ... into slot s
  task wn(input logic [2:0] s, input logic [4:0] n);
    for (int i = 0; i < n; i++)
    begin
      nwe <= 1'b1;
      nsel <= s;
      npos <= i[3:0];
      nlen <= n;
      nch <= 8'h41 + 8'(i);
      @(posedge core_clk);
    end
    nwe <= 1'b0;
    @(posedge core_clk);
  endtask
  // Beat to the second device; f is head, fend, last
  task put(input logic [7:0] d, input logic [2:0] f);
    lnk[1].h2d_valid <= 1'b1;
    lnk[1].h2d_data <= d;
    {lnk[1].h2d_head, lnk[1].h2d_fend, lnk[1].h2d_last} <= f;
    do
      @(posedge core_clk);
    while (lnk[1].h2d_ready !== 1'b1);
  endtask
  task idle;
    lnk[1].h2d_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task tally_and_finish;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    int t;
    lnk[1].h2d_valid = 1'b0;
    lnk[1].h2d_data = 8'h00;
    {lnk[1].h2d_head, lnk[1].h2d_fend, lnk[1].h2d_last} = 3'h0;
    lnk[1].d2h_ready = 1'b1;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd(REG_STATUS, 32'h0, "status");
    rd(8'hfc, 32'h0, "unmapped");
    wn(3'h0, 5'h10);
    wn(3'h1, 5'h01);
    // Masked report sets status only
    wb(1'b1, REG_CTRL, 32'h1);
    t = 0;
    do
    begin
      wb(1'b0, REG_STATUS, 32'h0);
      t++;
    end while (q[0] !== 1'b1 && t < 100);
    chk({31'h0, irq}, 32'h0, "masked");
    wb(1'b1, REG_MASK, 32'h3);
    wirq;
    // Report fields at their bounds
    for (int i = 0; i < 3; i++)
    begin
      cap_lim <= lims[i];
      n_used <= uses[i];
      wb(1'b1, REG_STATUS, 32'h1);
      wb(1'b1, REG_CTRL, 32'h1);
      wirq;
      rd(REG_CAP, caps[i], "cap");
    end
    // Sessions of two names and of none
    cap_lim <= 7'h63;
    for (int j = 0; j < 2; j++)
    begin
      n_used <= j ? 4'h0 : 4'h2;
      wb(1'b1, REG_STATUS, 32'h3);
      wb(1'b1, REG_CTRL, 32'h2);
      wirq;
      rd(REG_RECORD_COUNT, j ? 32'h0 : 32'h0202, "record_count");
    end
    wb(1'b1, REG_STATUS, 32'h2);
    rd(REG_STATUS, 32'h0, "w1c");
    // Faulty far end on the second link
    put(8'h23, 3'b100);
    put(8'h41, 3'b011);
    idle;
    chk({29'h0, ev}, 32'h1, "bad rec");
    put(8'h22, 3'b100);
    put(8'h32, 3'b011);
    put(8'h23, 3'b100);
    put(8'h5a, 3'b011);
    chk({31'h0, sopen[1]}, 32'h1, "open");
    put(8'h24, 3'b101);
    idle;
    chk({31'h0, sopen[1]}, 32'h0, "closed");
    chk({29'h0, ev}, 32'h3, "mismatch");
    t = 0;
    while (errw !== CAUSE_RECORD_COUNT && t < 50)
    begin
      @(posedge core_clk);
      t++;
    end
    chk(errw, CAUSE_RECORD_COUNT, "cause");
    put(8'h25, 3'b100);
    for (int i = 3; i >= 0; i--)
      put(CAUSE_RECORD_COUNT[8 * i +: 8], {1'b0, i == 0, i == 0});
    idle;
    chk({29'h0, ev}, 32'h7, "err rx");
    tally_and_finish;
  end
endmodule // tb
